// >>> logic/rlf_receiver.sv
// Device end: input link checking and output towards the central trigger unit
// Overview of operation
// - Input links 8b/10b at 11.2/12.8 Gb/s
// - Word is 224 or 256 bits
// - Sender adds CRC, receiver checks it
// - Commas at startup, fill symbol 0x3C replacing empty 0x00
// - Commas only at fixed unique byte positions
// - Bunch count embedded, used for alignment, monitoring
// - Electrical output: raw 80 Mb/s bits
// - Optical output: CRC, comma, bunch count
// - Optical 6.4 Gb/s, spares 12.8, bunch-synchronous
// - Both rates supported, never mixed per quad
// - Real-time logic timed by 40.079 MHz bunch clock
// - Bunch crossing period taken as 24.95 ns
`timescale 1ns/1ps
module rlf_receiver
  import rlf_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Timing and configuration
  input  wire logic         i_bunch_clk,
  input  wire logic         i_quad_rate_high,
  input  wire logic         i_err_clear,
  // Link
  rlf_link_if.dst           link,
  // Received data and status
  output logic [255:0]      o_payload,
  output logic              o_payload_valid,
  output logic              o_locked,
  output logic [11:0]       o_xing_offset,
  output logic              o_crc_err,
  output logic              o_comma_err,
  output logic              o_rate_err,
  output logic              o_xing_err,
  // Trigger results towards central trigger unit
  input  wire logic [15:0]  i_result,
  input  wire logic [15:0]  i_overflow,
  output logic [15:0]       o_trig_elec,
  output logic [127:0]      o_trig_opt_data,
  output logic [15:0]       o_trig_opt_k,
  output logic              o_trig_opt_valid
);
  import rlf_pkg::*;

  typedef struct packed {
    logic         s1;
    logic         s2;
    logic         sp;
    logic [11:0]  xing;
    logic [3:0]   good;
    logic         locked;
    logic [11:0]  off;
    logic         crc_err;
    logic         comma_err;
    logic         rate_err;
    logic         xing_err;
    logic [255:0] pay;
    logic         pay_v;
    logic [1:0]   half;
    logic [15:0]  elec;
    logic [127:0] opt;
    logic [15:0]  optk;
    logic         opt_v;
  } rlf_rx_t;

  rlf_rx_t      st;
  rlf_rx_t      next_st;
  logic [255:0] dec;
  logic [255:0] ow;
  logic [5:0]   nb;
  logic [15:0]  crc;
  logic [15:0]  ocrc;
  logic [11:0]  rx_xing;
  logic [11:0]  diff;
  logic         idle;
  logic         stray;
  logic         word_ok;
  logic         crossing;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st       = st;
    next_st.s1    = i_bunch_clk;
    next_st.s2    = st.s1;
    next_st.sp    = st.s2;
    next_st.pay_v = 1'b0;
    next_st.opt_v = 1'b0;
    crossing      = st.s2 && !st.sp;
    nb            = i_quad_rate_high ? NBYTES_HI : NBYTES_LO;
    dec           = link.data;
    idle          = (link.kflag == '1) && (link.data == {32{SYM_COMMA}});
    stray         = 1'b0;
    for (int i = 1; i < 32; i++) begin
      if (link.kflag[i] && link.data[8*i+:8] == SYM_FILL) begin
        dec[8*i+:8] = 8'h00;
      end
      if (i < int'(nb) && link.kflag[i] && link.data[8*i+:8] == SYM_COMMA) begin
        stray = 1'b1;
      end
    end
    crc     = rlf_crc16(dec, nb);
    word_ok = link.kflag[POS_COMMA] && link.data[8*POS_COMMA+:8] == SYM_COMMA
              && !stray && crc == {dec[8*(int'(nb)-2)+:8], dec[8*(int'(nb)-1)+:8]};
    rx_xing = {dec[8*POS_XING_HI+:4], dec[8*POS_XING_LO+:8]};
    diff    = rx_xing - st.xing;

    if (crossing) begin
      next_st.xing = st.xing + 12'h001;
    end

    if (i_err_clear) begin
      next_st.crc_err   = 1'b0;
      next_st.comma_err = 1'b0;
      next_st.rate_err  = 1'b0;
      next_st.xing_err  = 1'b0;
    end

    if (link.valid && !idle) begin
      if (link.rate_high != i_quad_rate_high) begin
        next_st.rate_err = 1'b1;
        next_st.locked   = 1'b0;
        next_st.good     = 4'h0;
      end else if (word_ok) begin
        next_st.pay   = '0;
        for (int i = POS_PAYLOAD; i < 32; i++) begin
          if (i < int'(nb) - 2) begin
            next_st.pay[8*(i-POS_PAYLOAD)+:8] = dec[8*i+:8];
          end
        end
        next_st.pay_v = st.locked;
        if (!st.locked) begin
          next_st.good = st.good + 4'h1;
          if (st.good + 4'h1 == LOCK_WORDS) begin
            next_st.locked = 1'b1;
            next_st.off    = diff;
          end
        end else if (diff != st.off) begin
          next_st.xing_err = 1'b1;
        end
      end else begin
        next_st.crc_err   = next_st.crc_err | !stray;
        next_st.comma_err = next_st.comma_err | stray;
        next_st.locked    = 1'b0;
        next_st.good      = 4'h0;
      end
    end

    ow   = '0;
    ocrc = '0;
    if (crossing) begin
      next_st.elec = i_result;
      next_st.half = HALF_XING_CYCLES;
      ow[8*POS_COMMA+:8]          = SYM_COMMA;
      ow[8*POS_XING_LO+:8]        = st.xing[7:0];
      ow[8*POS_XING_HI+:8]        = {4'h0, st.xing[11:8]};
      ow[8*POS_TRIG_RESULT+:16]   = i_result;
      ow[8*POS_TRIG_OVERFLOW+:16] = i_overflow;
      ocrc                        = rlf_crc16(ow, TRIG_NBYTES);
      ow[8*(int'(TRIG_NBYTES)-2)+:16] = {ocrc[7:0], ocrc[15:8]};
      next_st.opt                 = ow[127:0];
      next_st.optk                = 16'h0001;
      next_st.opt_v               = 1'b1;
    end else if (st.half != 2'h0) begin
      next_st.half = st.half - 2'h1;
      if (st.half == 2'h1) begin
        next_st.elec = i_overflow;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st    <= '0;
      st.xing <= XING_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_payload       = st.pay;
  assign o_payload_valid = st.pay_v;
  assign o_locked        = st.locked;
  assign o_xing_offset    = st.off;
  assign o_crc_err        = st.crc_err;
  assign o_comma_err      = st.comma_err;
  assign o_rate_err       = st.rate_err;
  assign o_xing_err       = st.xing_err;
  assign o_trig_elec      = st.elec;
  assign o_trig_opt_data  = st.opt;
  assign o_trig_opt_k     = st.optk;
  assign o_trig_opt_valid = st.opt_v;

endmodule

// >>> logic/rlf_pkg.sv
// Shared constants and checksum function for the real-time link framing
package rlf_pkg;

  // ****************************************
  // Line rates and word sizes
  // ****************************************
  localparam int LINE_RATE_LO_MBPS   = 11200;
  localparam int LINE_RATE_HI_MBPS   = 12800;
  localparam int WORD_BITS_LO        = 224;
  localparam int WORD_BITS_HI        = 256;
  localparam logic [5:0] NBYTES_LO   = 6'(WORD_BITS_LO / 8);
  localparam logic [5:0] NBYTES_HI   = 6'(WORD_BITS_HI / 8);
  localparam int TRIG_OPT_RATE_MBPS   = 6400;
  localparam int TRIG_SPARE_RATE_MBPS = 12800;
  localparam int TRIG_ELEC_RATE_MBPS  = 80;
  localparam logic [5:0] TRIG_NBYTES  = 6'h10;
  localparam int TRIG_BITS            = 16;

  // ****************************************
  // Byte positions and control symbols
  // ****************************************
  localparam int POS_COMMA          = 0;
  localparam int POS_XING_LO        = 1;
  localparam int POS_XING_HI        = 2;
  localparam int POS_PAYLOAD        = 3;
  localparam int POS_TRIG_RESULT    = 3;
  localparam int POS_TRIG_OVERFLOW  = 5;
  localparam logic [7:0] SYM_COMMA  = 8'hBC;
  localparam logic [7:0] SYM_FILL   = 8'h3C;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS      = 10000;
  localparam int XING_PERIOD_PS       = 24950;
  localparam int HALF_XING_CYCLES_RAW = XING_PERIOD_PS / (2 * CLK_PERIOD_PS);
  localparam logic [1:0] HALF_XING_CYCLES =
    2'((HALF_XING_CYCLES_RAW < 1) ? 1 : HALF_XING_CYCLES_RAW);
  localparam logic [3:0] STARTUP_WORDS = 4'h8;
  localparam logic [3:0] LOCK_WORDS    = 4'h4;

  // ****************************************
  // Reset values and CRC
  // ****************************************
  localparam logic [11:0] XING_RESET = 12'h000;
  localparam logic [15:0] CRC_INIT  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY  = 16'h1021;

  // CRC over bytes 1 .. nbytes-3 of a word
  function automatic logic [15:0] rlf_crc16(input logic [255:0] w,
                                            input logic [5:0]   nbytes);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 1; i < 32; i++) begin
      if (i < int'(nbytes) - 2) begin
        for (int b = 7; b >= 0; b--) begin
          if (c[15] ^ w[8*i+b]) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
          end else begin
            c = {c[14:0], 1'b0};
          end
        end
      end
    end
    return c;
  endfunction

endpackage

// >>> logic/rlf_link_if.sv
// Parallel word view of one real-time input link
`timescale 1ns/1ps
interface rlf_link_if;
  logic [255:0] data;
  logic [31:0]  kflag;
  logic         valid;
  logic         rate_high;

  modport src (output data, output kflag, output valid, output rate_high);
  modport dst (input data, input kflag, input valid, input rate_high);
endinterface

// >>> logic/rlf_source.sv
// Upstream sending end of one real-time input link
`timescale 1ns/1ps
module rlf_source
  import rlf_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Timing and user data
  input  wire logic         i_bunch_clk,
  input  wire logic         i_rate_high,
  input  wire logic [255:0] i_payload,
  output logic              o_started,
  // Link
  rlf_link_if.src           link
);
  import rlf_pkg::*;

  typedef struct packed {
    logic         s1;
    logic         s2;
    logic         sp;
    logic [11:0]  xing;
    logic [3:0]   boot;
    logic         started;
    logic [255:0] data;
    logic [31:0]  kflag;
    logic         valid;
    logic         rate;
  } rlf_src_t;

  rlf_src_t     st;
  rlf_src_t     next_st;
  logic [255:0] w;
  logic [31:0]  k;
  logic [15:0]  crc;
  logic [5:0]   nb;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st       = st;
    next_st.s1    = i_bunch_clk;
    next_st.s2    = st.s1;
    next_st.sp    = st.s2;
    next_st.valid = 1'b0;
    next_st.started = (st.boot == STARTUP_WORDS);
    nb            = i_rate_high ? NBYTES_HI : NBYTES_LO;
    w             = '0;
    k             = '0;
    crc           = '0;
    if (st.s2 && !st.sp) begin
      next_st.xing  = st.xing + 12'h001;
      next_st.valid = 1'b1;
      next_st.rate  = i_rate_high;
      if (st.boot != STARTUP_WORDS) begin
        next_st.boot  = st.boot + 4'h1;
        next_st.data  = {32{SYM_COMMA}};
        next_st.kflag = '1;
      end else begin
        w[8*POS_COMMA+:8] = SYM_COMMA;
        k[POS_COMMA]      = 1'b1;
        w[8*POS_XING_LO+:8] = st.xing[7:0];
        w[8*POS_XING_HI+:8] = {4'h0, st.xing[11:8]};
        for (int i = POS_PAYLOAD; i < 32; i++) begin
          if (i < int'(nb) - 2) begin
            w[8*i+:8] = i_payload[8*(i-POS_PAYLOAD)+:8];
          end
        end
        crc = rlf_crc16(w, nb);
        w[8*(int'(nb)-2)+:8] = crc[15:8];
        w[8*(int'(nb)-1)+:8] = crc[7:0];
        for (int i = POS_PAYLOAD; i < 32; i++) begin
          if (i < int'(nb) - 2 && w[8*i+:8] == 8'h00) begin
            w[8*i+:8] = SYM_FILL;
            k[i]      = 1'b1;
          end
        end
        next_st.data  = w;
        next_st.kflag = k;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st    <= '0;
      st.xing <= XING_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.data      = st.data;
  assign link.kflag     = st.kflag;
  assign link.valid     = st.valid;
  assign link.rate_high = st.rate;
  assign o_started      = st.started;

endmodule

// >>> verif/rlf_link_chk.sv
// Wire checks on the link joining source and receiver
`timescale 1ns/1ps
module rlf_link_chk
  import rlf_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Link signals
  input  wire logic [255:0] i_data,
  input  wire logic [31:0]  i_kflag,
  input  wire logic         i_valid,
  input  wire logic         i_rate_high
);
  import rlf_pkg::*;

  logic [3:0]  n_start;
  logic [11:0] last_xing;
  logic [11:0] rx_xing;
  logic        have_xing;
  logic        bad_k;
  logic        dat;

  // Control bytes after byte zero allowed only as payload filler
  always_comb begin
    dat     = i_valid && !i_kflag[1];
    rx_xing = {i_data[19:16], i_data[15:8]};
    bad_k   = 1'b0;
    for (int i = 1; i < 32; i++) begin
      if (i_kflag[i] && (i_data[8*i+:8] != SYM_FILL || i < POS_PAYLOAD
          || i > int'(i_rate_high ? NBYTES_HI : NBYTES_LO) - 3)) begin
        bad_k = 1'b1;
      end
    end
  end

  // Startup word count and last bunch count
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      n_start   <= 4'h0;
      have_xing <= 1'b0;
      last_xing <= 12'h000;
    end else if (i_valid && i_kflag[1]) begin
      n_start <= n_start + 4'h1;
    end else if (i_valid) begin
      have_xing <= 1'b1;
      last_xing <= rx_xing;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  AST_COMMA_POS: assert property (i_valid |-> i_data[7:0] == SYM_COMMA && i_kflag[0])
    else $error("no comma in byte zero");
  AST_K_FILL: assert property (dat |-> !bad_k)
    else $error("stray control byte");
  AST_VALID_PULSE: assert property (i_valid |=> !i_valid)
    else $error("valid too long");
  AST_DATA_HOLD: assert property ($changed(i_data) |-> i_valid)
    else $error("word changed without valid");
  AST_XING_STEP: assert property (dat && have_xing |->
    rx_xing == last_xing + 12'h001)
    else $error("bunch count step");
  AST_XING_HIGH: assert property (dat |-> i_data[23:20] == 4'h0)
    else $error("bunch count high nibble");
  AST_STARTUP: assert property (i_valid && n_start < STARTUP_WORDS |->
    i_kflag[1] && i_data[15:8] == SYM_COMMA)
    else $error("startup word not comma");
  AST_STARTUP_END: assert property (i_valid && n_start == STARTUP_WORDS |->
    !i_kflag[1])
    else $error("startup too long");

  cover property (dat && |i_kflag[31:3]);
  cover property (dat && i_rate_high);
  cover property (dat && n_start == STARTUP_WORDS);
endmodule

// >>> verif/realtime_link_framing_bench.sv
// Bench joining both ends, plus a second receiver fed with faulty words
`timescale 1ns/1ps
module realtime_link_framing_bench;
  logic         clk = 1'b0;
  logic         resetn = 1'b0;
  logic         bclk = 1'b0;
  logic         srate = 1'b0;
  logic         qrate = 1'b0;
  logic         clr = 1'b0;
  logic [255:0] pl = 256'h0;
  logic [15:0]  res = 16'h0;
  logic [15:0]  ovf = 16'h0;
  logic [255:0] pay;
  logic [127:0] od;
  logic [127:0] e;
  logic [15:0]  elec, ok, c;
  logic [11:0]  off;
  logic         started, pv, lk, ce, me, re, be, ov, lk2, ce2, me2, be2;
  int           num_errors = 0;
  int           n_checks = 0;

  rlf_link_if link_a ();
  rlf_link_if link_b ();
  rlf_source rlf_source_inst (.i_clk(clk), .i_resetn(resetn), .i_bunch_clk(bclk),
    .i_rate_high(srate), .i_payload(pl), .o_started(started), .link(link_a.src));
  rlf_receiver rlf_receiver_inst (.i_clk(clk), .i_resetn(resetn), .i_bunch_clk(bclk),
    .i_quad_rate_high(qrate), .i_err_clear(clr), .link(link_a.dst), .o_payload(pay),
    .o_payload_valid(pv), .o_locked(lk), .o_xing_offset(off), .o_crc_err(ce),
    .o_comma_err(me), .o_rate_err(re), .o_xing_err(be), .i_result(res), .i_overflow(ovf),
    .o_trig_elec(elec), .o_trig_opt_data(od), .o_trig_opt_k(ok), .o_trig_opt_valid(ov));
  rlf_receiver rlf_receiver_inst2 (.i_clk(clk), .i_resetn(resetn), .i_bunch_clk(bclk),
    .i_quad_rate_high(1'b0), .i_err_clear(clr), .link(link_b.dst), .o_payload(),
    .o_payload_valid(), .o_locked(lk2), .o_xing_offset(), .o_crc_err(ce2), .o_comma_err(me2),
    .o_rate_err(), .o_xing_err(be2), .i_result(res), .i_overflow(ovf), .o_trig_elec(),
    .o_trig_opt_data(), .o_trig_opt_k(), .o_trig_opt_valid());
  rlf_link_chk rlf_link_chk_inst (.i_clk(clk), .i_resetn(resetn), .i_data(link_a.data),
    .i_kflag(link_a.kflag), .i_valid(link_a.valid), .i_rate_high(link_a.rate_high));

  always #5 clk = ~clk;
  always #20 bclk = ~bclk;

  function automatic logic [15:0] crc16(input logic [255:0] d, input logic [31:0] k,
                                        input int nb);
    logic [15:0] x;
    x = 16'hFFFF;
    for (int i = 1; i < nb - 2; i++) begin
      for (int b = 7; b >= 0; b--) begin
        x = {x[14:0], 1'b0} ^ ((x[15] ^ (d[8*i+b] & ~k[i])) ? 16'h1021 : 16'h0);
      end
    end
    return x;
  endfunction

  task chk(input logic [255:0] g, input logic [255:0] x, input string m);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask

  // One word per crossing on the faulty link: 0 good, 1 bad checksum, 2 stray comma
  task send_b(input logic [11:0] xing, input int kind);
    logic [255:0] d;
    logic [15:0]  x;
    d = {216'h0, 8'hA5, 8'h0, 4'h0, xing, 8'hBC};
    x = crc16(d, 32'h1, 28) ^ ((kind == 1) ? 16'h0001 : 16'h0);
    d[223:208] = {x[7:0], x[15:8]};
    if (kind == 2) d[47:40] = 8'hBC;
    @(posedge bclk);
    @(posedge clk);
    @(negedge clk);
    link_b.data = d;
    link_b.kflag = (kind == 2) ? 32'h21 : 32'h1;
    link_b.valid = 1'b1;
    @(negedge clk);
    link_b.valid = 1'b0;
    @(negedge clk);
  endtask

  task wrap_up;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    wrap_up;
  end

  initial begin
    link_b.data = 256'h0;
    link_b.kflag = 32'h0;
    link_b.valid = 1'b0;
    link_b.rate_high = 1'b0;
    for (int j = 0; j < 32; j++) pl[8*j+:8] = (j % 3 == 0) ? 8'h00 : 8'(j) + 8'h40;
    res = 16'hA5C3;
    ovf = 16'h3C5A;
    for (int r = 0; r < 3; r++) begin
      srate = (r == 1);
      qrate = (r > 0);
      resetn = 1'b0;
      repeat (6) @(negedge clk);
      resetn = 1'b1;
      for (int i = 0; i < 300 && lk !== 1'b1; i++) @(negedge clk);
      if (r == 2) begin
        chk(re & ~lk, 1'b1, "rate mismatch");
      end else begin
        for (int i = 0; i < 40 && pv !== 1'b1; i++) @(negedge clk);
        chk(pay, pl & ((256'h1 << (r ? 216 : 184)) - 256'h1), "payload");
        chk(started & ~(ce | me | re | be), 1'b1, "clean link");
        chk(off, 12'hFFF, "alignment offset");
        for (int i = 0; i < 10 && ov !== 1'b1; i++) @(negedge clk);
        e = {72'h0, ovf, res, od[23:8], 8'hBC};
        c = crc16({128'h0, e}, 32'h0, 16);
        e[127:112] = {c[7:0], c[15:8]};
        chk({od, ok, elec}, {e, 16'h0001, res}, "optical word");
        @(negedge clk);
        chk(elec, ovf, "overflow bits");
      end
    end
    for (int i = 0; i < 5; i++) send_b(12'(i), 0);
    chk(lk2, 1'b1, "lock");
    send_b(12'h005, 1);
    chk(ce2 & ~lk2, 1'b1, "bad checksum");
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    chk(ce2, 1'b0, "clear");
    send_b(12'h006, 2);
    chk(me2 & ~ce2, 1'b1, "stray comma");
    for (int i = 7; i < 12; i++) send_b(12'(i), 0);
    send_b(12'h00D, 0);
    chk(be2, 1'b1, "count slip");
    wrap_up;
  end
endmodule
